// ### hdl/nv_cmd_host.sv
// Wishbone-facing command host that drives the controller link
`default_nettype none
module nv_cmd_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Processor side
  output logic             halt_o,
  output logic             hard_fault_o,
  // Controller link
  nv_link_if.host_mp       link
);
  import nv_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_HALT = 2'b01,
    H_REQ  = 2'b11
  } hstate_t;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  hstate_t            state_r;
  cmd_t               cmd_r;
  logic               uca_r;
  logic [1:0]         size_r;
  logic [31:0]        addr_r;
  logic [31:0]        wdata_r;
  logic [31:0]        rdata_r;
  logic               req_r;
  logic               halt_r;
  logic               fault_st_r;
  logic               done_st_r;
  logic               hf_r;
  logic               ack_r;
  logic [31:0]        dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire        acc      = wb_cyc_i && wb_stb_i && !ack_r;
  // Writes land at the edge where the master samples ack
  wire        wr       = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  wire        wr_ctrl  = wr && (wb_adr_i == REG_CTRL) && (state_r == H_IDLE) && wb_sel_i[0];
  wire        wr_stat  = wr && (wb_adr_i == REG_STAT);
  wire        got      = (state_r == H_REQ) && link.ack;
  wire [31:0] stat_val = {28'h0, done_st_r, fault_st_r, state_r != H_IDLE, link.ready};
  wire [31:0] rd_val   = (wb_adr_i == REG_ADDR)  ? addr_r :
                         (wb_adr_i == REG_WDATA) ? wdata_r :
                         (wb_adr_i == REG_STAT)  ? stat_val :
                         (wb_adr_i == REG_RDATA) ? rdata_r : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      dat_r   <= 32'h0;
      addr_r  <= 32'h0;
      wdata_r <= 32'h0;
    end else begin
      ack_r <= acc;
      if (acc) begin
        dat_r <= rd_val;
      end
      if (wr && wb_adr_i == REG_ADDR) begin
        addr_r <= merge(addr_r, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == REG_WDATA) begin
        wdata_r <= merge(wdata_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= H_IDLE;
      cmd_r      <= CMD_STAT;
      uca_r      <= 1'b0;
      size_r     <= SIZE_WORD;
      req_r      <= 1'b0;
      halt_r     <= 1'b0;
      rdata_r    <= 32'h0;
      fault_st_r <= 1'b0;
      done_st_r  <= 1'b0;
      hf_r       <= 1'b0;
    end else begin
      hf_r <= got && link.fault;
      fault_st_r <= (got && link.fault) || (fault_st_r && !(wr_stat && wb_sel_i[0] && wb_dat_i[ST_FAULT]));
      done_st_r  <= got || (done_st_r && !(wr_stat && wb_sel_i[0] && wb_dat_i[ST_DONE]));
      unique case (state_r)
        H_IDLE: begin
          if (wr_ctrl) begin
            cmd_r  <= cmd_t'(wb_dat_i[2:0]);
            uca_r  <= wb_dat_i[CTRL_UCA];
            size_r <= wb_dat_i[CTRL_SZ_LO +: 2];
            if (wb_dat_i[CTRL_DBG]) begin
              halt_r  <= 1'b1;
              state_r <= H_HALT;
            end else begin
              req_r   <= 1'b1;
              state_r <= H_REQ;
            end
          end
        end
        H_HALT: begin
          req_r   <= 1'b1;
          state_r <= H_REQ;
        end
        H_REQ: begin
          if (got) begin
            req_r   <= 1'b0;
            halt_r  <= 1'b0;
            rdata_r <= link.rdata;
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
  assign halt_o       = halt_r;
  assign hard_fault_o = hf_r;
  assign link.req     = req_r;
  assign link.cmd     = cmd_r;
  assign link.uca     = uca_r;
  assign link.size    = size_r;
  assign link.addr    = addr_r[FADDR_W-1:0];
  assign link.wdata   = wdata_r;
endmodule
`default_nettype wire

// ### hdl/nv_link_if.sv
// Link between the command host and the write/erase controller
`default_nettype none
interface nv_link_if;
  import nv_pkg::*;
  logic               req;
  cmd_t               cmd;
  logic               uca;
  logic [FADDR_W-1:0] addr;
  logic [1:0]         size;
  logic [31:0]        wdata;
  logic               ack;
  logic               fault;
  logic [31:0]        rdata;
  logic               ready;
  modport host_mp (output req, cmd, uca, addr, size, wdata, input ack, fault, rdata, ready);
  modport dev_mp  (input req, cmd, uca, addr, size, wdata, output ack, fault, rdata, ready);
endinterface
`default_nettype wire

// ### hdl/nv_pkg.sv
// Shared constants and types for the flash write/erase controller and its host
`default_nettype none
package nv_pkg;
  // Clock and times
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned WRITE_TIME_NS      = 40000;
  localparam int unsigned SECTOR_WIPE_TIME_NS = 2000000;
  localparam int unsigned FULL_WIPE_TIME_NS  = 4000000;
  localparam int unsigned CHUNK_UNIT_NS      = 1000;
  localparam int unsigned WRITE_CYC_DEF      = (WRITE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SECTOR_WIPE_CYC_DEF = (SECTOR_WIPE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FULL_WIPE_CYC_DEF  = (FULL_WIPE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CHUNK_UNIT_CYC_DEF = (CHUNK_UNIT_NS * CLK_MHZ + 999) / 1000;

  // Array geometry
  localparam int unsigned PAGE_BYTES  = 4096;
  localparam int unsigned PAGE_BLOCKS = 8;
  localparam int unsigned BLOCK_BYTES = PAGE_BYTES / PAGE_BLOCKS;
  localparam int unsigned PAGE_WORDS  = PAGE_BYTES / 4;
  localparam int unsigned NUM_PAGES   = 2;
  localparam int unsigned FLASH_WORDS = NUM_PAGES * PAGE_WORDS;
  localparam int unsigned UCA_WORDS   = 64;
  localparam int unsigned FADDR_W     = $clog2(FLASH_WORDS * 4);
  localparam int unsigned PG_W        = $clog2(NUM_PAGES);
  localparam int unsigned WIDX_W      = $clog2(FLASH_WORDS);
  localparam int unsigned UIDX_W      = $clog2(UCA_WORDS);
  localparam int unsigned PG_LSB      = $clog2(PAGE_BYTES);
  localparam int unsigned WEAR_W      = 16;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [31:0] UNDEF_WORD  = 32'h00000000;

  // Enable setting
  typedef enum logic [1:0] {
    MODE_RO  = 2'h0,
    MODE_WEN = 2'h1,
    MODE_EEN = 2'h2
  } mode_t;

  // Link commands
  typedef enum logic [2:0] {
    CMD_PROG       = 3'h0,
    CMD_CFG        = 3'h1,
    CMD_CHUNK_CFG  = 3'h2,
    CMD_STAT       = 3'h3,
    CMD_PAGE_WIPE  = 3'h4,
    CMD_UCA_WIPE   = 3'h5,
    CMD_ALL_WIPE   = 3'h6,
    CMD_CHUNK_WIPE = 3'h7
  } cmd_t;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [7:0] CHUNK_RST = 8'h0a;

  // Host register map and fields
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int unsigned CTRL_UCA   = 3;
  localparam int unsigned CTRL_SZ_LO = 4;
  localparam int unsigned CTRL_DBG   = 6;
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_BUSY  = 1;
  localparam int unsigned ST_FAULT = 2;
  localparam int unsigned ST_DONE  = 3;
endpackage
`default_nettype wire

// ### hdl/nv_write_erase_controller.sv
// Flash and user configuration area write/erase controller with its array
`default_nettype none
module nv_write_erase_controller #(
  parameter int unsigned WRITE_CYC       = nv_pkg::WRITE_CYC_DEF,
  parameter int unsigned SECTOR_WIPE_CYC = nv_pkg::SECTOR_WIPE_CYC_DEF,
  parameter int unsigned FULL_WIPE_CYC   = nv_pkg::FULL_WIPE_CYC_DEF,
  parameter int unsigned CHUNK_UNIT_CYC  = nv_pkg::CHUNK_UNIT_CYC_DEF
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Command link
  nv_link_if.dev_mp                        link,
  // Read ports: [0] instruction_fetch_bus, [1] data_fetch_bus
  input  wire logic [1:0]                  rd_req_i,
  input  wire logic [1:0][nv_pkg::FADDR_W-1:0] rd_addr_i,
  output logic      [1:0]                  rd_ack_o,
  output logic      [1:0][31:0]            rd_data_o,
  // Live user configuration word
  output logic      [31:0]                 uca_live_o
);
  import nv_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_PROG  = 2'b01,
    D_WIPE  = 2'b11,
    D_CHUNK = 2'b10
  } dstate_t;

  typedef enum logic [1:0] {
    K_PAGE = 2'h0,
    K_UCA  = 2'h1,
    K_ALL  = 2'h2
  } kind_t;

  function automatic logic [PG_W-1:0] page_of(input logic [FADDR_W-1:0] a);
    return a[FADDR_W-1:PG_LSB];
  endfunction

  function automatic logic [WIDX_W-1:0] word_of(input logic [FADDR_W-1:0] a);
    return a[FADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state
  logic [31:0]           flash_mem [FLASH_WORDS];
  logic [31:0]           uca_mem   [UCA_WORDS];
  logic [31:0]           acc_r     [NUM_PAGES];
  logic [WEAR_W-1:0]     wear_r    [NUM_PAGES];
  logic [NUM_PAGES-1:0]  undef_r;
  dstate_t               state_r;
  kind_t                 kind_r;
  mode_t                 mode_r;
  logic [7:0]            chunk_r;
  logic [31:0]           tmr_r;
  logic [FADDR_W-1:0]    op_addr_r;
  logic                  op_uca_r;
  logic [31:0]           op_data_r;
  logic                  ack_r;
  logic                  fault_r;
  logic [31:0]           rdata_r;
  logic                  ready_r;
  logic [1:0]            rd_ack_r;
  logic [1:0][31:0]      rd_data_r;
  logic [31:0]           uca_live_r;
  logic                  uca_loaded_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire              take      = link.req && !ack_r && (state_r == D_IDLE);
  wire              word_ok   = (link.size == SIZE_WORD) && (link.addr[1:0] == 2'b00);
  wire              can_write = (mode_r == MODE_WEN);
  wire              can_erase = (mode_r == MODE_EEN);
  wire              go_prog   = take && (link.cmd == CMD_PROG) && can_write && word_ok;
  wire              bad_size  = take && (link.cmd == CMD_PROG) && can_write && !word_ok;
  wire              go_page   = take && (link.cmd == CMD_PAGE_WIPE) && can_erase && !link.uca;
  wire              go_uca    = take && (link.cmd == CMD_UCA_WIPE) && can_erase && link.wdata[0];
  wire              go_all    = take && (link.cmd == CMD_ALL_WIPE) && can_erase && link.wdata[0];
  wire              go_chunk  = take && (link.cmd == CMD_CHUNK_WIPE) && can_erase && !link.uca;
  wire [PG_W-1:0]   op_pg     = page_of(op_addr_r);
  wire [31:0]       chunk_cyc = 32'((chunk_r == 8'h00 ? 8'h01 : chunk_r) * CHUNK_UNIT_CYC);
  wire [31:0]       chunk_sum = acc_r[op_pg] + tmr_r + chunk_cyc - tmr_r;
  wire              chunk_end = (chunk_sum >= SECTOR_WIPE_CYC);
  wire              done      = (state_r != D_IDLE) && (tmr_r == 32'h0);
  wire              prog_done = done && (state_r == D_PROG);
  wire              fill_page = done && ((state_r == D_WIPE && kind_r == K_PAGE) ||
                                         (state_r == D_CHUNK && chunk_end));
  wire              fill_uca  = done && (state_r == D_WIPE) && (kind_r == K_UCA);
  wire              fill_all  = done && (state_r == D_WIPE) && (kind_r == K_ALL);
  wire [31:0]       wipe_cyc  = 32'(go_all ? FULL_WIPE_CYC - 1 : SECTOR_WIPE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= D_IDLE;
      kind_r    <= K_PAGE;
      mode_r    <= MODE_RO;
      chunk_r   <= CHUNK_RST;
      tmr_r     <= 32'h0;
      op_addr_r <= '0;
      op_uca_r  <= 1'b0;
      op_data_r <= 32'h0;
      ack_r     <= 1'b0;
      fault_r   <= 1'b0;
      rdata_r   <= 32'h0;
      ready_r   <= 1'b1;
    end else begin
      ack_r   <= 1'b0;
      fault_r <= 1'b0;
      if (take) begin
        op_addr_r <= link.addr;
        op_uca_r  <= link.uca;
        op_data_r <= link.wdata;
      end
      if (go_prog) begin
        state_r <= D_PROG;
        tmr_r   <= 32'(WRITE_CYC - 1);
        ready_r <= 1'b0;
      end else if (go_page || go_uca || go_all) begin
        state_r <= D_WIPE;
        kind_r  <= go_all ? K_ALL : (go_uca ? K_UCA : K_PAGE);
        tmr_r   <= wipe_cyc;
        ready_r <= 1'b0;
        ack_r   <= 1'b1;
      end else if (go_chunk) begin
        state_r <= D_CHUNK;
        tmr_r   <= chunk_cyc - 32'h1;
        ready_r <= 1'b0;
        ack_r   <= 1'b1;
      end else if (take) begin
        ack_r   <= 1'b1;
        fault_r <= bad_size;
        if (link.cmd == CMD_CFG) begin
          mode_r <= mode_t'(link.wdata[1:0]);
        end
        if (link.cmd == CMD_CHUNK_CFG) begin
          chunk_r <= link.wdata[7:0];
        end
        rdata_r <= {wear_r[page_of(link.addr)], 15'h0, ready_r};
      end else if (done) begin
        state_r <= D_IDLE;
        ready_r <= 1'b1;
        ack_r   <= prog_done;
      end else if (state_r != D_IDLE) begin
        tmr_r <= tmr_r - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page accounting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      undef_r <= '0;
      for (int p = 0; p < NUM_PAGES; p++) begin
        acc_r[p]  <= 32'h0;
        wear_r[p] <= '0;
      end
    end else if (fill_all) begin
      undef_r <= '0;
      for (int p = 0; p < NUM_PAGES; p++) begin
        acc_r[p]  <= 32'h0;
        wear_r[p] <= wear_r[p] + 1'b1;
      end
    end else if (fill_page) begin
      undef_r[op_pg] <= 1'b0;
      acc_r[op_pg]   <= 32'h0;
      wear_r[op_pg]  <= wear_r[op_pg] + 1'b1;
    end else if (done && state_r == D_CHUNK) begin
      undef_r[op_pg] <= 1'b1;
      acc_r[op_pg]   <= chunk_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array
  always_ff @(posedge clk_i) begin
    if (prog_done && !op_uca_r) begin
      flash_mem[word_of(op_addr_r)] <= flash_mem[word_of(op_addr_r)] & op_data_r;
    end
    if (prog_done && op_uca_r) begin
      uca_mem[op_addr_r[UIDX_W+1:2]] <= uca_mem[op_addr_r[UIDX_W+1:2]] & op_data_r;
    end
    for (int w = 0; w < FLASH_WORDS; w++) begin
      if (fill_all || (fill_page && (w / PAGE_WORDS) == int'(op_pg))) begin
        flash_mem[w] <= ERASED_WORD;
      end
    end
    for (int u = 0; u < UCA_WORDS; u++) begin
      if (fill_all || fill_uca) begin
        uca_mem[u] <= ERASED_WORD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read ports and configuration capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ack_r     <= 2'b00;
      rd_data_r    <= '0;
      uca_live_r   <= 32'h0;
      uca_loaded_r <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        rd_ack_r[b] <= rd_req_i[b] && !rd_ack_r[b] && (state_r == D_IDLE);
        rd_data_r[b] <= undef_r[page_of(rd_addr_i[b])] ? UNDEF_WORD :
                        flash_mem[word_of(rd_addr_i[b])];
      end
      if (!uca_loaded_r) begin
        uca_live_r   <= uca_mem[0];
        uca_loaded_r <= 1'b1;
      end
    end
  end

  assign link.ack   = ack_r;
  assign link.fault = fault_r;
  assign link.rdata = rdata_r;
  assign link.ready = ready_r;
  assign rd_ack_o   = rd_ack_r;
  assign rd_data_o  = rd_data_r;
  assign uca_live_o = uca_live_r;
endmodule
`default_nettype wire

// ### verification/nv_link_asserts.sv
// Link handshake and operation timing checks
`default_nettype none
module nv_link_asserts #(
  parameter int unsigned WRITE_CYC       = 8,
  parameter int unsigned SECTOR_WIPE_CYC = 40,
  parameter int unsigned FULL_WIPE_CYC   = 60
) (
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // Link signals
  input wire logic                       req,
  input wire nv_pkg::cmd_t               cmd,
  input wire logic [nv_pkg::FADDR_W-1:0] addr,
  input wire logic [1:0]                 size,
  input wire logic [31:0]                wdata,
  input wire logic                       ack,
  input wire logic                       fault,
  input wire logic [31:0]                rdata,
  input wire logic                       ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import nv_pkg::*;

  logic [31:0] low_cnt_r;
  cmd_t        op_r;

  // Length of the current busy stretch
  always_ff @(posedge clk_i) begin
    if (rst_i || ready) begin
      low_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= low_cnt_r + 32'h1;
    end
  end

  // Command of the last taken request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r <= CMD_PROG;
    end else if (req && ready && !ack) begin
      op_r <= cmd;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////
  prog_length_a: assert property (
    $rose(ready) && op_r == CMD_PROG |-> ack && low_cnt_r == WRITE_CYC) else $error("program length wrong");
  page_length_a: assert property (
    $rose(ready) && (op_r == CMD_PAGE_WIPE || op_r == CMD_UCA_WIPE) |-> low_cnt_r == SECTOR_WIPE_CYC)
    else $error("page wipe length wrong");
  full_length_a: assert property (
    $rose(ready) && op_r == CMD_ALL_WIPE |-> low_cnt_r == FULL_WIPE_CYC) else $error("full wipe length wrong");
  ack_pulse_a: assert property (
    ack |=> !ack) else $error("ack longer than one cycle");
  ack_cause_a: assert property (
    ack |-> $past(req)) else $error("ack without request");
  req_hold_a: assert property (
    req && !ack |=> req && $stable(cmd) && $stable(addr) && $stable(wdata) && $stable(size))
    else $error("request changed before ack");
  req_drop_a: assert property (
    ack |=> !req) else $error("request kept after ack");
  quick_ack_a: assert property (
    req && ready && !ack && cmd != CMD_PROG |=> ack) else $error("command not acked next cycle");
  fault_cause_a: assert property (
    fault |-> ack && cmd == CMD_PROG && (size != SIZE_WORD || addr[1:0] != 2'h0))
    else $error("fault without bad program");
  stat_word_a: assert property (
    ack && cmd == CMD_STAT |-> rdata[15:0] == 16'h0001) else $error("status word wrong");

  cover property ($rose(ready) && op_r == CMD_PROG);
  cover property (fault);
  cover property ($rose(ready) && op_r == CMD_CHUNK_WIPE);
  cover property (ack && cmd == CMD_ALL_WIPE && wdata[0]);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Testbench joining host and controller over the link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nv_pkg::*;

  typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_t;
  logic                      clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [7:0]                wb_adr;
  logic [3:0]                wb_sel;
  logic [31:0]               wb_dat, wb_dat_o, uca_live, d, d2, p, q, rnd;
  logic                      halt, hard_fault, halt_q;
  int                        n_halt, n_halt_exp, n_hf;
  logic [1:0]                rd_req, rd_ack;
  logic [1:0][FADDR_W-1:0]   rd_addr;
  logic [1:0][31:0]          rd_data;
  int                        n_mismatch, check_count;
  integer                    seed;
  note_t                     nt;
  note_t                     notes[$];

  nv_link_if nv_link_if_inst ();
  nv_write_erase_controller #(.WRITE_CYC(8), .SECTOR_WIPE_CYC(40), .FULL_WIPE_CYC(60), .CHUNK_UNIT_CYC(4))
    nv_write_erase_controller_inst (.clk_i(clk_i), .rst_i(rst_i), .link(nv_link_if_inst), .rd_req_i(rd_req),
    .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_data_o(rd_data), .uca_live_o(uca_live));
  nv_cmd_host nv_cmd_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .halt_o(halt), .hard_fault_o(hard_fault), .link(nv_link_if_inst));
  nv_link_asserts nv_link_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .req(nv_link_if_inst.req), .cmd(nv_link_if_inst.cmd),
    .addr(nv_link_if_inst.addr), .size(nv_link_if_inst.size), .wdata(nv_link_if_inst.wdata),
    .ack(nv_link_if_inst.ack), .fault(nv_link_if_inst.fault), .rdata(nv_link_if_inst.rdata),
    .ready(nv_link_if_inst.ready));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo;
    n_mismatch++;
    close_out();
  endtask

  // Result watcher: oldest note against each returned value
  always @(posedge clk_i) begin
    if ((wb_ack_o === 1'b1 && !wb_we) || rd_ack[0] === 1'b1 || rd_ack[1] === 1'b1) begin
      if (notes.size() > 0) begin
        nt = notes.pop_front();
        if (nt.m != 0) begin
          cmp(nt.n, nt.e & nt.m, (wb_ack_o ? wb_dat_o : rd_ack[0] ? rd_data[0] : rd_data[1]) & nt.m);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Processor-side pulse counters
  always @(posedge clk_i) begin
    halt_q <= halt;
    if (halt === 1'b1 && halt_q === 1'b0) n_halt++;
    if (hard_fault === 1'b1) n_hf++;
  end

  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] dd, input logic [31:0] m);
    int i;
    if (!wr) notes.push_back('{"wb read", dd, m});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= wr;
    wb_adr <= a;
    wb_dat <= dd;
    wb_sel <= 4'hf;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) tmo();
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input int b, input logic [12:0] a, input logic [31:0] e);
    int i;
    notes.push_back('{"read port", e, 32'hffffffff});
    rd_req[b]  <= 1'b1;
    rd_addr[b] <= a;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (rd_ack[b] !== 1'b1 && i < 100);
    if (i >= 100) tmo();
    rd_req[b] <= 1'b0;
    @(posedge clk_i);
  endtask

  // Launch one command, wait for done and idle, check flags
  task automatic run(input cmd_t c, input logic u, input logic [1:0] s, input logic [12:0] a,
                     input logic [31:0] dd, input logic f);
    int i;
    wb(1'b1, REG_ADDR, {19'h0, a}, 32'h0);
    wb(1'b1, REG_WDATA, dd, 32'h0);
    rnd = $random(seed);
    if (rnd[0]) n_halt_exp++;
    wb(1'b1, REG_CTRL, {25'h0, rnd[0], s, u, c}, 32'h0);
    i = 0;
    q = 32'h0;
    while ((q[3:0] & 4'h9) !== 4'h9 && i < 100) begin
      wb(1'b0, REG_STAT, 32'h0, 32'h0);
      i++;
    end
    if (i >= 100) tmo();
    wb(1'b0, REG_STAT, {28'h0, 1'b1, f, 1'b0, 1'b1}, 32'hf);
    wb(1'b1, REG_STAT, 32'hc, 32'h0);
  endtask

  task automatic cfg(input mode_t m);
    run(CMD_CFG, 1'b0, SIZE_WORD, 13'h0, {30'h0, m}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5c6d;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    rd_req = 2'h0;
    rd_addr = '0;
    n_mismatch = 0;
    check_count = 0;
    n_halt = 0;
    n_halt_exp = 0;
    n_hf = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h1, 32'hf);
    wb(1'b0, 8'h40, 32'h0, 32'hffffffff);
    cfg(MODE_EEN);
    run(CMD_PAGE_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h0, 1'b0);
    rd(0, 13'h010, ERASED_WORD);
    rd(1, 13'h014, ERASED_WORD);
    cfg(MODE_WEN);
    d = $random(seed);
    d2 = $random(seed);
    run(CMD_PROG, 1'b0, SIZE_WORD, 13'h010, d, 1'b0);
    rd(1, 13'h010, d);
    run(CMD_PROG, 1'b0, SIZE_WORD, 13'h010, d2, 1'b0);
    rd(0, 13'h010, d & d2);
    run(CMD_PROG, 1'b0, SIZE_WORD, 13'h1004, d2, 1'b0);
    for (int k = 0; k < 3; k++) run(CMD_PROG, 1'b0, 2'(k), 13'h016, 32'h0, 1'b1);
    cmp("hard fault pulses", 32'h3, n_hf);
    rd(0, 13'h014, ERASED_WORD);
    for (int k = 0; k < 2; k++) begin
      cfg(k == 0 ? MODE_RO : MODE_EEN);
      run(CMD_PROG, 1'b0, SIZE_WORD, 13'h014, 32'h0, 1'b0);
      rd(1, 13'h014, ERASED_WORD);
    end
    cfg(MODE_RO);
    run(CMD_PAGE_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h0, 1'b0);
    rd(0, 13'h010, d & d2);
    cfg(MODE_EEN);
    run(CMD_ALL_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h0, 1'b0);
    rd(0, 13'h010, d & d2);
    run(CMD_ALL_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h1, 1'b0);
    rd(0, 13'h010, ERASED_WORD);
    rd(1, 13'h1004, ERASED_WORD);
    run(CMD_CHUNK_CFG, 1'b0, SIZE_WORD, 13'h0, 32'h5, 1'b0);
    run(CMD_STAT, 1'b0, SIZE_WORD, 13'h1000, 32'h0, 1'b0);
    wb(1'b0, REG_RDATA, 32'h00010001, 32'hffffffff);
    run(CMD_CHUNK_WIPE, 1'b0, SIZE_WORD, 13'h1000, 32'h0, 1'b0);
    rd(1, 13'h1008, UNDEF_WORD);
    run(CMD_CHUNK_WIPE, 1'b0, SIZE_WORD, 13'h1000, 32'h0, 1'b0);
    rd(1, 13'h1008, ERASED_WORD);
    run(CMD_STAT, 1'b0, SIZE_WORD, 13'h1000, 32'h0, 1'b0);
    wb(1'b0, REG_RDATA, 32'h00020001, 32'hffffffff);
    run(CMD_UCA_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h1, 1'b0);
    cfg(MODE_WEN);
    p = $random(seed);
    run(CMD_PROG, 1'b1, SIZE_WORD, 13'h0, p, 1'b0);
    cfg(MODE_EEN);
    run(CMD_CHUNK_WIPE, 1'b1, SIZE_WORD, 13'h0, 32'h0, 1'b0);
    run(CMD_UCA_WIPE, 1'b0, SIZE_WORD, 13'h0, 32'h0, 1'b0);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp("user area word", p, uca_live);
    cmp("halt launches", n_halt_exp, n_halt);
    close_out();
  end
endmodule
`default_nettype wire
